// ==== rtl/tsc_regs.svh ====
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH
// command codes
`define TSC_CMD_RD_LOCAL  8'h00
`define TSC_CMD_RD_REMOTE 8'h01
`define TSC_CMD_RD_STATUS 8'h02
`define TSC_CMD_RD_CONFIG 8'h03
`define TSC_CMD_RD_RATE   8'h04
`define TSC_CMD_RD_LHI    8'h05
`define TSC_CMD_RD_LLO    8'h06
`define TSC_CMD_RD_RHI    8'h07
`define TSC_CMD_RD_RLO    8'h08
`define TSC_CMD_WR_CONFIG 8'h09
`define TSC_CMD_WR_RATE   8'h0A
`define TSC_CMD_ONE_SHOT  8'h0F
// config and status fields
`define TSC_CFG_MASK      7
`define TSC_CFG_STANDBY_PIN      6
`define TSC_RATE_RESET    8'h02
`define TSC_ST_BUSY       7
`define TSC_ST_LHI        6
`define TSC_ST_LLO        5
`define TSC_ST_RHI        4
`define TSC_ST_RLO        3
`define TSC_ST_OPEN       2
`define TSC_COLLIDE       7'h7F
`define TSC_LIM_HI_RESET  8'h7F
`define TSC_LIM_LO_RESET  8'hC9
// strap levels and addresses
`define TSC_STRAP_GND     2'h0
`define TSC_STRAP_HIZ     2'h1
`define TSC_STRAP_VCC     2'h2
`define TSC_ADDR_GG       7'h18
`define TSC_ADDR_GZ       7'h19
`define TSC_ADDR_GV       7'h1A
`define TSC_ADDR_ZG       7'h29
`define TSC_ADDR_ZZ       7'h2A
`define TSC_ADDR_ZV       7'h2B
`define TSC_ADDR_VG       7'h4C
`define TSC_ADDR_VZ       7'h4D
`define TSC_ADDR_VV       7'h4E
// timing
`define TSC_CLK_KHZ       250000
`define TSC_TICK_MS       125
`define TSC_CONV_MS       125
`define TSC_TICK_CYCLES   (`TSC_TICK_MS * `TSC_CLK_KHZ)
`define TSC_CONV_CYCLES   (`TSC_CONV_MS * `TSC_CLK_KHZ)
`endif

// ==== rtl/tsc_pkg.sv ====
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'h0,
    TSC_WAIT = 2'h1,
    TSC_CONV = 2'h3
  } tsc_state_e;
  typedef enum logic [1:0] {
    TSC_K_WRITE = 2'h0,
    TSC_K_SEND  = 2'h1,
    TSC_K_READ  = 2'h2,
    TSC_K_ALERT = 2'h3
  } tsc_kind_e;
endpackage

// ==== rtl/tsc_sched.sv ====
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_sched #(
  parameter int unsigned TICK_CYCLES = `TSC_TICK_CYCLES,
  parameter int unsigned CONV_CYCLES = `TSC_CONV_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       standby_i,
  input  wire logic       one_shot_i,
  input  wire logic       rate_wr_i,
  input  wire logic [2:0] rate_i,
  input  wire logic       uvlo_i,
  // converter timing
  output logic            busy_o,
  output logic            start_o,
  output logic            done_o
);
  tsc_pkg::tsc_state_e state;
  logic [31:0] pre_cnt;
  logic [7:0]  tick_cnt;
  logic [31:0] conv_cnt;
  logic        pend;
  logic        standby_pin_q;
  logic        standby_pin_rise;
  logic        tick;
  logic [7:0]  interval;

  assign standby_pin_rise = standby_i && !standby_pin_q;
  assign tick      = (pre_cnt == TICK_CYCLES - 1);
  assign interval  = 8'h01 << (3'h7 - rate_i); // [RULE_11] [RULE_12]
  assign busy_o    = (state == tsc_pkg::TSC_CONV); // [RULE_23]
  assign done_o    = busy_o && !standby_pin_rise && (conv_cnt == CONV_CYCLES - 1); // [RULE_13]
  // uvlo holds any start back, the request stays pending
  assign start_o   = !uvlo_i && ( // [RULE_18]
                     (state == tsc_pkg::TSC_IDLE && pend) ||
                     (state == tsc_pkg::TSC_WAIT && !standby_i &&
                      (pend || tick_cnt >= interval)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= tsc_pkg::TSC_WAIT;
      standby_pin_q <= 1'b0;
    end else begin
      standby_pin_q <= standby_i;
      case (state)
        tsc_pkg::TSC_IDLE: begin
          if (start_o) state <= tsc_pkg::TSC_CONV;
          else if (!standby_i) state <= tsc_pkg::TSC_WAIT;
        end
        tsc_pkg::TSC_WAIT: begin
          if (start_o) state <= tsc_pkg::TSC_CONV;
          else if (standby_i) state <= tsc_pkg::TSC_IDLE;
        end
        tsc_pkg::TSC_CONV: begin
          if (standby_pin_rise) state <= tsc_pkg::TSC_IDLE; // [RULE_02]
          else if (done_o) begin
            state <= standby_i ? tsc_pkg::TSC_IDLE : tsc_pkg::TSC_WAIT; // [RULE_19]
          end
        end
        default: state <= tsc_pkg::TSC_IDLE;
      endcase
    end
  end

  // power-up asks for a first conversion at once
  always_ff @(posedge clk_i) begin
    if (rst_i) pend <= 1'b1;
    else if (start_o) pend <= 1'b0;
    else if (one_shot_i && !busy_o) pend <= 1'b1; // [RULE_15] [RULE_19]
    else if (!standby_i && standby_pin_q) pend <= 1'b1; // [RULE_02]
    else if (state == tsc_pkg::TSC_WAIT && standby_i) pend <= 1'b0;
  end

  // interval counts from each start, restarted by a rate write
  always_ff @(posedge clk_i) begin
    if (rst_i || start_o || rate_wr_i || tick) pre_cnt <= 32'h0; // [RULE_24]
    else pre_cnt <= pre_cnt + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start_o || rate_wr_i) tick_cnt <= 8'h00; // [RULE_14] [RULE_19]
    else if (tick && tick_cnt != 8'hFF) tick_cnt <= tick_cnt + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) conv_cnt <= 32'h0;
    else conv_cnt <= conv_cnt + 32'h1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_standby_pin_stop;
    standby_pin_rise && busy_o |=> state == tsc_pkg::TSC_IDLE && !busy_o;
  endproperty
  a_standby_pin_stop: assert property (p_standby_pin_stop) else $error("standby did not stop"); // [RULE_02]
  property p_ignore;
    busy_o && one_shot_i && standby_i == standby_pin_q |=> $stable(pend);
  endproperty
  a_ignore: assert property (p_ignore) else $error("one-shot kept in conversion"); // [RULE_15]
  property p_uvlo;
    uvlo_i |-> !start_o;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("start under uvlo"); // [RULE_18]
  property p_busy;
    start_o |=> busy_o && conv_cnt == 32'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised at start"); // [RULE_23]
  property p_timer;
    start_o && !pend |-> tick_cnt >= interval;
  endproperty
  a_timer: assert property (p_timer) else $error("timer start early"); // [RULE_11]
  c_standby_shot: cover property (state == tsc_pkg::TSC_IDLE && start_o);
endmodule

// ==== rtl/tsc_link.sv ====
`timescale 1ns/1ps
module tsc_link (
  // link clock domain
  input  wire logic       link_clk_i,
  input  wire logic       req_i,
  input  wire logic [1:0] kind_i,
  input  wire logic [7:0] cmd_i,
  input  wire logic [7:0] data_i,
  input  wire logic       stop_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic            nack_o,
  // core domain
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  output logic            req_o,
  output logic [1:0]      kind_o,
  output logic [7:0]      cmd_o,
  output logic [7:0]      data_o,
  output logic            stop_o,
  input  wire logic       ack_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       nack_i
);
  logic lrst_m, lrst;
  logic req_tgl, stop_tgl, ack_tgl;
  logic ack_m, ack_s, ack_q;
  logic req_m, req_s, req_q;
  logic stop_m, stop_s, stop_q;

  always_ff @(posedge link_clk_i) begin
    lrst_m <= rst_i;
    lrst   <= lrst_m;
  end

  assign busy_o = req_tgl ^ ack_s;

  // fields stay put until the answer returns, so the core reads them safely
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      req_tgl <= 1'b0;
      kind_o  <= 2'h0;
      cmd_o   <= 8'h00;
      data_o  <= 8'h00;
    end else if (req_i && !busy_o) begin
      req_tgl <= ~req_tgl;
      kind_o  <= kind_i;
      cmd_o   <= cmd_i;
      data_o  <= data_i;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) stop_tgl <= 1'b0;
    else if (stop_i) stop_tgl <= ~stop_tgl;
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      ack_m   <= 1'b0;
      ack_s   <= 1'b0;
      ack_q   <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 8'h00;
      nack_o  <= 1'b0;
    end else begin
      ack_m  <= ack_tgl;
      ack_s  <= ack_m;
      ack_q  <= ack_s;
      done_o <= ack_s ^ ack_q;
      if (ack_s ^ ack_q) begin
        rdata_o <= rdata_i;
        nack_o  <= nack_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_m  <= 1'b0;
      req_s  <= 1'b0;
      req_q  <= 1'b0;
      stop_m <= 1'b0;
      stop_s <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      req_m  <= req_tgl;
      req_s  <= req_m;
      req_q  <= req_s;
      stop_m <= stop_tgl;
      stop_s <= stop_m;
      stop_q <= stop_s;
    end
  end

  assign req_o  = req_s ^ req_q;
  assign stop_o = stop_s ^ stop_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_tgl <= 1'b0;
    else if (ack_i) ack_tgl <= ~ack_tgl;
  end
endmodule

// ==== rtl/tsc_top.sv ====
// How it works
// RULE_01 - mask bit silences the interrupt output
// RULE_02 - standby bit stops conversion, enters standby
// RULE_03 - config readable, low six bits ignored
// RULE_04 - status: busy, four limits, open, zeros
// RULE_05 - flags sticky until read unless fault persists
// RULE_06 - interrupt latch independent of status clearing
// RULE_07 - host rereads status showing seven ones
// RULE_08 - limit flags refreshed after stop condition
// RULE_09 - open flag updated only at conversion start
// RULE_10 - host waits for one-shot to finish
// RULE_11 - rate codes 0..7 select conversion interval
// RULE_12 - rate resets to 02h, three bits decoded
// RULE_13 - results valid one conversion time after start
// RULE_14 - rate change restarts interval timer
// RULE_15 - one-shot during conversion is ignored
// RULE_16 - strap address latched once after reset
// RULE_17 - also answers the alert response read
// RULE_18 - reset clears registers, uvlo blocks starts
// RULE_19 - one-shot: single run, or restart timer
// RULE_20 - command codes select registers and one-shot
// RULE_21 - limit met sets flag and interrupt latch
// RULE_22 - only alert response read clears latch
// RULE_23 - busy high from start to results written
// RULE_24 - rate timer from prescaled core clock
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_top #(
  parameter int unsigned TICK_CYCLES = `TSC_TICK_CYCLES,
  parameter int unsigned CONV_CYCLES = `TSC_CONV_CYCLES,
  parameter logic [7:0]  LOCAL_HIGH  = `TSC_LIM_HI_RESET,
  parameter logic [7:0]  LOCAL_LOW   = `TSC_LIM_LO_RESET,
  parameter logic [7:0]  REMOTE_HIGH = `TSC_LIM_HI_RESET,
  parameter logic [7:0]  REMOTE_LOW  = `TSC_LIM_LO_RESET
) (
  // core clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       RESET_I,
  // serial link, serial clock domain
  input  wire logic       SMB_CLK_I,
  input  wire logic       LINK_REQ_I,
  input  wire logic [1:0] LINK_KIND_I,
  input  wire logic [7:0] LINK_CMD_I,
  input  wire logic [7:0] LINK_DATA_I,
  input  wire logic       LINK_STOP_I,
  output logic            LINK_BUSY_O,
  output logic            LINK_DONE_O,
  output logic [7:0]      LINK_RDATA_O,
  output logic            LINK_NACK_O,
  // pins
  input  wire logic       STANDBY_PIN_I,
  input  wire logic [1:0] ADDR_STRAP_A_I,
  input  wire logic [1:0] ADDR_STRAP_B_I,
  output logic            ALERT_O,
  output logic            ALERT_OE_O,
  output logic [6:0]      SLAVE_ADDR_O,
  // converter
  input  wire logic       UVLO_I,
  input  wire logic       DIODE_OPEN_I,
  input  wire logic [7:0] LOCAL_SAMPLE_I,
  input  wire logic [7:0] REMOTE_SAMPLE_I,
  output logic            CONV_START_O,
  output logic            CONV_BUSY_O
);
  logic [1:0] strap_a_m, strap_a_s, strap_b_m, strap_b_s;
  logic       standby_pin_m, standby_pin_s, uvlo_m, uvlo_s, open_m, open_s;
  logic       strap_done;
  logic [6:0] slave_addr;
  logic       cfg_mask, cfg_standby_pin, next_mask;
  logic [7:0] rate, ptr;
  logic [7:0] local_temp_reg, remote_temp_reg;
  logic [4:0] flags, next_flags;
  logic [3:0] lim_cond, cmp;
  logic       open_cond;
  logic       alert, next_alert, alert_oe;
  logic       req, stop, ack, nack;
  logic [1:0] kind;
  logic [7:0] cmd, wdata, rdata;
  tsc_pkg::tsc_kind_e kind_e;
  logic       conv_busy, conv_start, conv_done;
  logic       one_shot, rate_wr, cfg_wr;
  logic       rd_status, collide, st_clear, ara_hit;
  logic [7:0] status_byte, reg_val;

  // pin synchronisers carry no reset so straps are valid at release
  always_ff @(posedge MCLK_I) begin
    strap_a_m <= ADDR_STRAP_A_I;
    strap_a_s <= strap_a_m;
    strap_b_m <= ADDR_STRAP_B_I;
    strap_b_s <= strap_b_m;
    standby_pin_m    <= STANDBY_PIN_I;
    standby_pin_s    <= standby_pin_m;
    uvlo_m    <= UVLO_I;
    uvlo_s    <= uvlo_m;
    open_m    <= DIODE_OPEN_I;
    open_s    <= open_m;
  end

  function automatic logic [6:0] addr_of(input logic [1:0] a, input logic [1:0] b);
    case ({a, b})
      {`TSC_STRAP_GND, `TSC_STRAP_GND}: addr_of = `TSC_ADDR_GG;
      {`TSC_STRAP_GND, `TSC_STRAP_HIZ}: addr_of = `TSC_ADDR_GZ;
      {`TSC_STRAP_GND, `TSC_STRAP_VCC}: addr_of = `TSC_ADDR_GV;
      {`TSC_STRAP_HIZ, `TSC_STRAP_GND}: addr_of = `TSC_ADDR_ZG;
      {`TSC_STRAP_HIZ, `TSC_STRAP_VCC}: addr_of = `TSC_ADDR_ZV;
      {`TSC_STRAP_VCC, `TSC_STRAP_GND}: addr_of = `TSC_ADDR_VG;
      {`TSC_STRAP_VCC, `TSC_STRAP_HIZ}: addr_of = `TSC_ADDR_VZ;
      {`TSC_STRAP_VCC, `TSC_STRAP_VCC}: addr_of = `TSC_ADDR_VV;
      default: addr_of = `TSC_ADDR_ZZ;
    endcase
  endfunction

  // straps are read once, the pins are never looked at again
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      strap_done <= 1'b0;
      slave_addr <= 7'h00;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      slave_addr <= addr_of(strap_a_s, strap_b_s); // [RULE_16]
    end
  end

  tsc_link u_link (
    .link_clk_i (SMB_CLK_I),
    .req_i      (LINK_REQ_I),
    .kind_i     (LINK_KIND_I),
    .cmd_i      (LINK_CMD_I),
    .data_i     (LINK_DATA_I),
    .stop_i     (LINK_STOP_I),
    .busy_o     (LINK_BUSY_O),
    .done_o     (LINK_DONE_O),
    .rdata_o    (LINK_RDATA_O),
    .nack_o     (LINK_NACK_O),
    .clk_i      (MCLK_I),
    .rst_i      (RESET_I),
    .req_o      (req),
    .kind_o     (kind),
    .cmd_o      (cmd),
    .data_o     (wdata),
    .stop_o     (stop),
    .ack_i      (ack),
    .rdata_i    (rdata),
    .nack_i     (nack)
  );

  tsc_sched #(
    .TICK_CYCLES (TICK_CYCLES),
    .CONV_CYCLES (CONV_CYCLES)
  ) u_sched (
    .clk_i      (MCLK_I),
    .rst_i      (RESET_I),
    .standby_i  (cfg_standby_pin | standby_pin_s),
    .one_shot_i (one_shot),
    .rate_wr_i  (rate_wr),
    .rate_i     (rate[2:0]),
    .uvlo_i     (uvlo_s),
    .busy_o     (conv_busy),
    .start_o    (conv_start),
    .done_o     (conv_done)
  );

  assign kind_e    = tsc_pkg::tsc_kind_e'(kind);
  assign cfg_wr    = req && kind_e == tsc_pkg::TSC_K_WRITE && cmd == `TSC_CMD_WR_CONFIG;
  assign rate_wr   = req && kind_e == tsc_pkg::TSC_K_WRITE && cmd == `TSC_CMD_WR_RATE;
  assign one_shot  = req && kind_e == tsc_pkg::TSC_K_SEND && cmd == `TSC_CMD_ONE_SHOT; // [RULE_20]
  assign rd_status = req && kind_e == tsc_pkg::TSC_K_READ && ptr == `TSC_CMD_RD_STATUS;
  // a status read landing on the result write returns the collision pattern
  assign collide   = rd_status && conv_done; // [RULE_07]
  assign st_clear  = rd_status && !collide;
  assign ara_hit   = req && kind_e == tsc_pkg::TSC_K_ALERT && alert; // [RULE_17]
  assign next_mask = cfg_wr ? wdata[`TSC_CFG_MASK] : cfg_mask;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin // [RULE_18]
      cfg_mask <= 1'b0;
      cfg_standby_pin <= 1'b0;
      rate     <= `TSC_RATE_RESET; // [RULE_12]
      ptr      <= 8'h00;
    end else if (req) begin
      if (kind_e == tsc_pkg::TSC_K_WRITE || kind_e == tsc_pkg::TSC_K_SEND) ptr <= cmd;
      if (cfg_wr) begin
        cfg_mask <= wdata[`TSC_CFG_MASK]; // [RULE_03]
        cfg_standby_pin <= wdata[`TSC_CFG_STANDBY_PIN]; // [RULE_02]
      end
      if (rate_wr) rate <= wdata;
    end
  end

  always_comb begin
    status_byte              = 8'h00; // [RULE_04]
    status_byte[`TSC_ST_BUSY] = conv_busy;
    status_byte[`TSC_ST_LHI]  = flags[4];
    status_byte[`TSC_ST_LLO]  = flags[3];
    status_byte[`TSC_ST_RHI]  = flags[2];
    status_byte[`TSC_ST_RLO]  = flags[1];
    status_byte[`TSC_ST_OPEN] = flags[0];
  end

  always_comb begin
    case (ptr) // [RULE_20]
      `TSC_CMD_RD_LOCAL:  reg_val = local_temp_reg;
      `TSC_CMD_RD_REMOTE: reg_val = remote_temp_reg;
      `TSC_CMD_RD_STATUS: reg_val = status_byte;
      `TSC_CMD_RD_CONFIG: reg_val = {cfg_mask, cfg_standby_pin, 6'h00}; // [RULE_03]
      `TSC_CMD_RD_RATE:   reg_val = rate;
      `TSC_CMD_RD_LHI:    reg_val = LOCAL_HIGH;
      `TSC_CMD_RD_LLO:    reg_val = LOCAL_LOW;
      `TSC_CMD_RD_RHI:    reg_val = REMOTE_HIGH;
      `TSC_CMD_RD_RLO:    reg_val = REMOTE_LOW;
      default:            reg_val = 8'h00;
    endcase
  end

  // answer goes back one cycle after the request, data with it
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ack   <= 1'b0;
      nack  <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ack <= req;
      if (req) begin
        nack <= kind_e == tsc_pkg::TSC_K_ALERT && !alert;
        if (kind_e == tsc_pkg::TSC_K_READ) begin
          rdata <= collide ? {conv_busy, `TSC_COLLIDE} : reg_val;
        end else if (kind_e == tsc_pkg::TSC_K_ALERT) begin
          rdata <= alert ? {slave_addr, 1'b1} : 8'hFF; // [RULE_17]
        end
      end
    end
  end

  always_comb begin
    cmp[3] = $signed(LOCAL_SAMPLE_I) >= $signed(LOCAL_HIGH); // [RULE_21]
    cmp[2] = $signed(LOCAL_SAMPLE_I) <= $signed(LOCAL_LOW);
    cmp[1] = $signed(REMOTE_SAMPLE_I) >= $signed(REMOTE_HIGH);
    cmp[0] = $signed(REMOTE_SAMPLE_I) <= $signed(REMOTE_LOW);
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      local_temp_reg  <= 8'h00;
      remote_temp_reg <= 8'h00;
      lim_cond        <= 4'h0;
      open_cond       <= 1'b0;
    end else begin
      if (conv_done) begin // [RULE_13]
        local_temp_reg  <= LOCAL_SAMPLE_I;
        remote_temp_reg <= REMOTE_SAMPLE_I;
        lim_cond        <= cmp;
      end
      if (conv_start) open_cond <= open_s; // [RULE_09]
    end
  end

  // every set is applied after the clear, so a coincident event survives
  always_comb begin
    next_flags = st_clear ? 5'h00 : flags; // [RULE_05]
    if (conv_done) next_flags[4:1] = next_flags[4:1] | cmp;
    if (stop) next_flags[4:1] = next_flags[4:1] | lim_cond; // [RULE_08]
    if (conv_start) next_flags[0] = next_flags[0] | open_s; // [RULE_09]
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) flags <= 5'h00;
    else flags <= next_flags;
  end

  // latch ignores status reads, only the alert response clears it
  assign next_alert = (alert && !ara_hit) || // [RULE_06] [RULE_22]
                      (conv_done && ((|cmp) || open_cond)); // [RULE_21]

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      alert    <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert    <= next_alert;
      alert_oe <= next_alert && !next_mask; // [RULE_01]
    end
  end

  assign ALERT_O      = 1'b0;
  assign ALERT_OE_O   = alert_oe;
  assign SLAVE_ADDR_O = slave_addr;
  assign CONV_START_O = conv_start;
  assign CONV_BUSY_O  = conv_busy;

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  property p_mask;
    cfg_mask |-> !ALERT_OE_O;
  endproperty
  a_mask: assert property (p_mask) else $error("alert driven while masked"); // [RULE_01]
  property p_cfg_read;
    req && kind_e == tsc_pkg::TSC_K_READ && ptr == `TSC_CMD_RD_CONFIG
      |=> rdata == {$past(cfg_mask), $past(cfg_standby_pin), 6'h00};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong"); // [RULE_03]
  property p_status;
    st_clear |=> rdata == $past(status_byte) && rdata[1:0] == 2'h0 && ack;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong"); // [RULE_04]
  property p_clear;
    st_clear && !conv_done && !stop && !conv_start |=> flags == 5'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared by read"); // [RULE_05]
  property p_latch;
    st_clear && alert && !ara_hit |=> alert;
  endproperty
  a_latch: assert property (p_latch) else $error("status read cleared latch"); // [RULE_06]
  property p_refresh;
    stop |=> (flags[4:1] & $past(lim_cond)) == $past(lim_cond);
  endproperty
  a_refresh: assert property (p_refresh) else $error("limit flags not refreshed"); // [RULE_08]
  property p_open;
    $rose(flags[0]) |-> $past(conv_start);
  endproperty
  a_open: assert property (p_open) else $error("open flag set off start"); // [RULE_09]
  property p_ara;
    $fell(alert) |-> $past(ara_hit);
  endproperty
  a_ara: assert property (p_ara) else $error("latch cleared without alert read"); // [RULE_22]
  property p_strap;
    strap_done |=> $stable(slave_addr);
  endproperty
  a_strap: assert property (p_strap) else $error("slave address changed"); // [RULE_16]
  property p_limit;
    conv_done && cmp[3] |=> flags[4] && alert;
  endproperty
  a_limit: assert property (p_limit) else $error("limit not flagged"); // [RULE_21]
  c_collide: cover property (collide);
  c_ara: cover property (ara_hit ##1 !alert);
  c_stop: cover property (stop && |lim_cond);
endmodule

// ==== bench/tsc_host.sv ====
`timescale 1ns/1ps
module tsc_host (
  // link clock and request
  output logic            clk_o,
  output logic            req_o,
  output logic [1:0]      kind_o,
  output logic [7:0]      cmd_o,
  output logic [7:0]      data_o,
  output logic            stop_o,
  // answer
  input  wire logic       busy_i,
  input  wire logic       done_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       nack_i
);
  logic run    = 1'b1;
  int   misses = 0;
  initial begin
    clk_o = 1'b0;
    req_o = 1'b0;
    kind_o = 2'h0;
    cmd_o = 8'h00;
    data_o = 8'h00;
    stop_o = 1'b0;
    // odd start offset keeps the link edges away from the core edges
    #1.3;
    // parks low between frames, like a real host clock
    forever #80 if (run || clk_o) clk_o = ~clk_o;
  end
  task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] rd, output logic nk);
    int n;
    run = 1'b1;
    @(negedge clk_o);
    while (busy_i === 1'b1) @(negedge clk_o);
    req_o = 1'b1;
    kind_o = k;
    cmd_o = c;
    data_o = d;
    @(negedge clk_o);
    req_o = 1'b0;
    n = 0;
    do begin
      @(posedge clk_o);
      #1;
      n++;
    end while (done_i !== 1'b1 && n < 12);
    if (done_i !== 1'b1) misses++;
    rd = rdata_i;
    nk = nack_i;
    @(negedge clk_o);
    // released lines must not keep the last value
    cmd_o = ~c;
    data_o = ~d;
    stop_o = 1'b1;
    @(negedge clk_o);
    stop_o = 1'b0;
    repeat (3) @(negedge clk_o);
    run = 1'b0;
  endtask
endmodule

// ==== bench/tsc_tb_top.sv ====
`timescale 1ns/1ps
`include "tsc_regs.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tsc_tb_top;
  logic clk, rst, smb, req, stop, busy, done, nack, uvlo, oe, start, cbusy, nk, dopen, alo;
  logic [1:0] kind, sa, sb;
  logic [7:0] cmd, data, rdata, lsamp, rd;
  logic [6:0] addr;
  logic [31:0] rows [7] = '{32'h09000402, 32'h09000300, 32'h093F0300, 32'h09800380,
                            32'h0A070407, 32'h0AFF04FF, 32'h0A072000};
  int errors, checks_done, starts, s0, n;
  tsc_top #(.TICK_CYCLES(20), .CONV_CYCLES(10), .LOCAL_HIGH(8'h30)) tsc_top_i (
    .MCLK_I(clk), .RESET_I(rst), .SMB_CLK_I(smb), .LINK_REQ_I(req), .LINK_KIND_I(kind),
    .LINK_CMD_I(cmd), .LINK_DATA_I(data), .LINK_STOP_I(stop), .LINK_BUSY_O(busy),
    .LINK_DONE_O(done), .LINK_RDATA_O(rdata), .LINK_NACK_O(nack), .STANDBY_PIN_I(1'b0),
    .ADDR_STRAP_A_I(sa), .ADDR_STRAP_B_I(sb), .ALERT_O(alo), .ALERT_OE_O(oe),
    .SLAVE_ADDR_O(addr), .UVLO_I(uvlo), .DIODE_OPEN_I(dopen), .LOCAL_SAMPLE_I(lsamp),
    .REMOTE_SAMPLE_I(8'h10), .CONV_START_O(start), .CONV_BUSY_O(cbusy));
  tsc_host tsc_host_i (.clk_o(smb), .req_o(req), .kind_o(kind), .cmd_o(cmd), .data_o(data),
    .stop_o(stop), .busy_i(busy), .done_i(done), .rdata_i(rdata), .nack_i(nack));
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    tsc_host_i.xfer(tsc_pkg::TSC_K_WRITE, c, d, rd, nk);
  endtask
  task automatic rdreg(input logic [7:0] c);
    tsc_host_i.xfer(tsc_pkg::TSC_K_SEND, c, 8'h00, rd, nk);
    tsc_host_i.xfer(tsc_pkg::TSC_K_READ, 8'h00, 8'h00, rd, nk);
  endtask
  task automatic gap();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (start !== 1'b1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst) starts <= 0;
    else if (start) starts <= starts + 1;
  end
  initial begin
    #300000;
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    rst = 1'b1;
    uvlo = 1'b1;
    lsamp = 8'h10;
    dopen = 1'b0;
    sa = `TSC_STRAP_VCC;
    sb = `TSC_STRAP_HIZ;
    // long enough for the link side synchroniser as well
    repeat (130) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    sa = `TSC_STRAP_GND;
    repeat (3) @(negedge clk);
    `CHK("addr", `TSC_ADDR_VZ, addr)
    // the link side leaves reset two of its own edges after the core
    repeat (3) @(posedge smb);
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rdreg(rows[i][15:8]);
      `CHK("reg", rows[i][7:0], rd)
    end
    `CHK("uvlo starts", 0, starts)
    $display("registers and uvlo done");
    @(negedge clk) uvlo = 1'b0;
    for (int r = 6; r < 8; r++) begin
      wr(8'h0A, 8'(r));
      gap();
      gap();
      // a start is taken one cycle after the last tick of its interval
      `CHK("interval", (20 << (7 - r)) + 1, n)
      repeat (5) @(negedge clk);
      `CHK("busy mid", 1'b1, cbusy)
    end
    $display("rates done");
    wr(8'h09, 8'h00);
    @(negedge clk) lsamp = 8'h40;
    repeat (60) @(negedge clk);
    `CHK("alert", 1'b1, oe)
    `CHK("alert level", 1'b0, alo)
    lsamp = 8'h10;
    repeat (60) @(negedge clk);
    wr(8'h09, 8'h40);
    // standby before status reads, so no collision reread is needed
    rdreg(8'h02);
    `CHK("status", 8'h40, rd)
    rdreg(8'h02);
    `CHK("status clr", 8'h00, rd)
    `CHK("alert kept", 1'b1, oe)
    tsc_host_i.xfer(tsc_pkg::TSC_K_ALERT, 8'h00, 8'h00, rd, nk);
    `CHK("ara", {`TSC_ADDR_VZ, 1'b1}, rd)
    `CHK("alert clr", 1'b0, oe)
    tsc_host_i.xfer(tsc_pkg::TSC_K_ALERT, 8'h00, 8'h00, rd, nk);
    `CHK("ara nack", 1'b1, nk)
    s0 = starts;
    tsc_host_i.xfer(tsc_pkg::TSC_K_SEND, 8'h0F, 8'h00, rd, nk);
    // wait out the conversion before looking
    repeat (200) @(negedge clk);
    `CHK("one shot", s0 + 1, starts)
    wr(8'h09, 8'h80);
    @(negedge clk) lsamp = 8'h40;
    repeat (60) @(negedge clk);
    `CHK("masked", 1'b0, oe)
    // the mask hides the latch, it does not stop it
    wr(8'h09, 8'h00);
    `CHK("unmasked", 1'b1, oe)
    $display("alert and standby done");
    wr(8'h09, 8'h40);
    @(negedge clk) dopen = 1'b1;
    // no conversion starts in standby, so the open fault is not seen yet
    rdreg(8'h02);
    `CHK("open idle", 8'h40, rd)
    tsc_host_i.xfer(tsc_pkg::TSC_K_SEND, 8'h0F, 8'h00, rd, nk);
    repeat (200) @(negedge clk);
    rdreg(8'h02);
    `CHK("open", 8'h44, rd)
    $display("open fault done");
    `CHK("link timeouts", 0, tsc_host_i.misses)
    finish_test();
  end
endmodule
